// ===== aclink_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R1) frame: 16-bit tag, twelve 20-bit slots
// (R2) frame bits numbered F0 to F255
// (R3) sync sampled high on falling edge starts frame
// (R4) bit at sync edge ends previous frame
// (R5) next falling edge latches frame bit zero
// (R6) controller sends samples msb first, left justified
// (R7) controller drives reserved bits as zero
// (R8) access needs frame valid and matching identity
// (R9) primary: read slot1 valid, write both valid
// (R10) secondary: slot1 and slot2 valid both clear
// (R11) slot one bit 19: one read, zero write
// (R12) index below direction bit, low bit zero
// (R13) slot two write value ignored on reads
// (R14) writes atomic, never split across frames
// (R15) slots three to eleven are samples
// (R16) slot map chooses which slot feeds outputs
// (R17) slot twelve gpio bits drive output pins
// (R18) input-configured gpio bits are discarded
// (R19) source select ignores slot twelve entirely
// (R20) no access while link not ready
// (R21) valid read answered in next inbound frame; code only pulses O_REG_READ
// (R22) slot valid tags qualify each sample
// (R23) primary answers only identity zero
module aclink_dev_end
  import aclink_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  aclink_if.dev link,
  input wire logic [1:0] I_CODEC_IDENTITY_SETTING,
  input wire logic [1:0] I_SLOT_MAP_SELECT,
  input wire logic I_ALTERNATE_SLOT_MAP,
  input wire logic I_GPIO_OUTPUT_SOURCE_SELECT,
  input wire logic [GPIO_W-1:0] I_GPIO_DIR_OUT,
  input wire logic [GPIO_W-1:0] I_GPIO_STATUS_VALUE,
  input wire logic I_LINK_READY,
  output logic O_REG_WRITE,
  output logic O_REG_READ,
  output logic [6:0] O_REGISTER_INDEX,
  output logic [15:0] O_WRITE_VALUE,
  output logic [19:0] O_LEFT_SAMPLE,
  output logic [19:0] O_RIGHT_SAMPLE,
  output logic O_SAMPLE_STROBE,
  output logic [GPIO_W-1:0] O_GPIO_OUT,
  output logic O_FRAME_START
);
  typedef struct packed
  {
    logic bclk_d;
    logic [BIT_CNT_W-1:0] pos;
    logic locked;
    logic [FRAME_BITS-1:0] shf;
    logic [FRAME_BITS-1:0] frame;
    logic frame_done;
    logic wr;
    logic rd;
    logic [6:0] idx;
    logic [15:0] wval;
    logic [19:0] left;
    logic [19:0] right;
    logic smp;
    logic [GPIO_W-1:0] gpio_pend;
    logic [GPIO_W-1:0] gpio;
    logic fstart;
  } st_t;
  st_t s_reg;
  st_t s_next;
  logic [2:0] pins;
  logic bclk_s;
  logic sync_s;
  logic sdo_s;
  aclink_sync2 u_sync (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_async({link.bit_clk, link.sync, link.sdata_out}),
    .o_sync(pins)
  );
  assign bclk_s = pins[2];
  assign sync_s = pins[1];
  assign sdo_s = pins[0];
  logic fall;
  assign fall = s_reg.bclk_d & ~bclk_s;
  // frame fields, frame bit F0 at the top of the vector
  logic [15:0] tag;
  logic [19:0] slot [1:NUM_SLOTS];
  assign tag = s_reg.frame[FRAME_BITS-1 -: TAG_BITS]; // R1
  genvar g;
  generate
    for (g = 1; g <= NUM_SLOTS; g++)
    begin : g_slot
      assign slot[g] = s_reg.frame[FRAME_BITS-TAG_BITS-(g-1)*SLOT_BITS-1 -: SLOT_BITS];
    end
  endgenerate
  logic [1:0] fid;
  logic id_ok;
  logic tags_ok;
  logic is_read;
  logic access;
  logic [3:0] lslot;
  logic [3:0] rslot;
  always_comb
  begin
    fid = tag[TAG_ID_HI:0];
    id_ok = tag[TAG_FRAME_VALID] && (fid == I_CODEC_IDENTITY_SETTING); // R8 R23
    is_read = slot[1][SLOT1_DIR_BIT]; // R11
    if (I_CODEC_IDENTITY_SETTING == PRIMARY_ID)
      tags_ok = tag[TAG_SLOT1_VALID] && (is_read || tag[TAG_SLOT2_VALID]); // R9 R14
    else
      tags_ok = !tag[TAG_SLOT1_VALID] && !tag[TAG_SLOT2_VALID]; // R10
    access = id_ok && tags_ok && !slot[1][INDEX_LSB] && I_LINK_READY; // R12 R20
    // slot pairs picked by map select, identity and alternate map
    case ({I_ALTERNATE_SLOT_MAP, I_SLOT_MAP_SELECT ^ I_CODEC_IDENTITY_SETTING}) // R16
      3'b000: lslot = 4'h3;
      3'b001: lslot = 4'h7;
      3'b010: lslot = 4'h6;
      3'b011: lslot = 4'h9;
      default: lslot = 4'h7;
    endcase
    rslot = (lslot == 4'h3) ? 4'h4 : (lslot == 4'h6) ? 4'h9 : lslot + 4'h1;
    if (rslot == 4'ha)
      rslot = 4'h6;
  end
  always_comb
  begin
    s_next = s_reg;
    s_next.bclk_d = bclk_s;
    s_next.frame_done = 1'b0;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    s_next.smp = 1'b0;
    s_next.fstart = 1'b0;
    if (fall)
    begin
      // sync high once 15 bits have passed, or before lock: this edge's data closes the old frame
      if (sync_s && (s_reg.pos >= 8'h0f || !s_reg.locked)) // R3 R4
      begin
        s_next.frame = {s_reg.shf[FRAME_BITS-2:0], sdo_s};
        s_next.frame_done = s_reg.locked;
        s_next.locked = 1'b1;
        s_next.pos = 8'h00; // R5
        s_next.fstart = 1'b1;
        s_next.gpio = s_reg.gpio_pend; // R17
      end
      else
      begin
        s_next.shf = {s_reg.shf[FRAME_BITS-2:0], sdo_s};
        s_next.pos = s_reg.pos + 8'h01; // R2
      end
    end
    if (s_reg.frame_done)
    begin
      if (access)
      begin
        s_next.rd = is_read; // R21
        s_next.wr = !is_read;
        s_next.idx = slot[1][INDEX_MSB:INDEX_LSB];
        if (!is_read)
          s_next.wval = slot[2][WDATA_MSB:WDATA_LSB]; // R13
      end
      // playback slots kept only when tagged valid
      if (tag[TAG_SLOT1_VALID - lslot + 4'h1]) // R15 R22
        s_next.left = slot[lslot];
      if (tag[TAG_SLOT1_VALID - rslot + 4'h1]) // R22
        s_next.right = slot[rslot];
      s_next.smp = tag[TAG_FRAME_VALID];
      if (tag[TAG_FRAME_VALID] && tag[TAG_SLOT12_VALID])
        s_next.gpio_pend = (slot[12][GPIO_MSB:GPIO_LSB] & I_GPIO_DIR_OUT) // R17 R18
          | (s_reg.gpio_pend & ~I_GPIO_DIR_OUT);
    end
    if (I_GPIO_OUTPUT_SOURCE_SELECT)
    begin
      s_next.gpio_pend = I_GPIO_STATUS_VALUE; // R19
      s_next.gpio = I_GPIO_STATUS_VALUE;
    end
  end
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign O_REG_WRITE = s_reg.wr;
  assign O_REG_READ = s_reg.rd;
  assign O_REGISTER_INDEX = s_reg.idx;
  assign O_WRITE_VALUE = s_reg.wval;
  assign O_LEFT_SAMPLE = s_reg.left;
  assign O_RIGHT_SAMPLE = s_reg.right;
  assign O_SAMPLE_STROBE = s_reg.smp;
  assign O_GPIO_OUT = s_reg.gpio & I_GPIO_DIR_OUT; // R18
  assign O_FRAME_START = s_reg.fstart;
endmodule : aclink_dev_end
`default_nettype wire

// ===== aclink_pkg.sv
package aclink_pkg;
  localparam int FRAME_BITS = 256;
  localparam int TAG_BITS = 16;
  localparam int SLOT_BITS = 20;
  localparam int NUM_SLOTS = 12;
  localparam int BIT_CNT_W = 8;
  localparam int GPIO_W = 5;
  // tag slot bit positions, counted from the last bit sent
  localparam int TAG_FRAME_VALID = 15;
  localparam int TAG_SLOT1_VALID = 14;
  localparam int TAG_SLOT2_VALID = 13;
  localparam int TAG_SLOT12_VALID = 3;
  localparam int TAG_ID_HI = 1;
  localparam int SLOT1_DIR_BIT = 19;
  localparam int INDEX_MSB = 18;
  localparam int INDEX_LSB = 12;
  localparam int WDATA_MSB = 19;
  localparam int WDATA_LSB = 4;
  localparam int GPIO_MSB = 8;
  localparam int GPIO_LSB = 4;
  localparam int LINK_DIV_HALF = 8;
  localparam logic [1:0] PRIMARY_ID = 2'h0;
  localparam logic [15:0] WDATA_RESET = 16'h0000;
  localparam logic [19:0] SAMPLE_RESET = 20'h00000;
  localparam logic [GPIO_W-1:0] GPIO_RESET = 5'h00;
endpackage : aclink_pkg

// ===== aclink_if.sv
`timescale 1ns/10ps
`default_nettype none
interface aclink_if;
  logic bit_clk;
  logic sync;
  logic sdata_out;
  modport dev (input bit_clk, input sync, input sdata_out);
  modport ctl (output bit_clk, output sync, output sdata_out);
endinterface : aclink_if
`default_nettype wire

// ===== aclink_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module aclink_sync2 (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);
  typedef struct packed
  {
    logic [2:0] meta;
    logic [2:0] stable;
  } st_t;
  st_t s_reg;
  st_t s_next;
  always_comb
  begin
    s_next.meta = i_async;
    s_next.stable = s_reg.meta;
  end
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign o_sync = s_reg.stable;
endmodule : aclink_sync2
`default_nettype wire

// ===== aclink_ctl_end.sv
`timescale 1ns/10ps
`default_nettype none
module aclink_ctl_end
  import aclink_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  aclink_if.ctl link,
  input wire logic [TAG_BITS-1:0] I_TAG,
  input wire logic [NUM_SLOTS*SLOT_BITS-1:0] I_SLOTS,
  output logic O_FRAME_START
);
  typedef struct packed
  {
    logic [3:0] div;
    logic bclk;
    logic [BIT_CNT_W-1:0] cnt;
    logic sync;
    logic sdo;
    logic [FRAME_BITS-1:0] shf;
    logic start;
  } st_t;
  st_t s_reg;
  st_t s_next;
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.div = s_reg.div + 4'h1;
    if (s_reg.div == 4'(LINK_DIV_HALF - 1))
    begin
      s_next.div = 4'h0;
      s_next.bclk = ~s_reg.bclk;
      if (!s_reg.bclk)
      begin
        // rising edge: drive next bit, sync high for 16 bits from the bit before the tag slot
        if (s_reg.cnt == 8'hff)
        begin
          s_next.shf = {I_TAG, I_SLOTS};
          s_next.start = 1'b1;
        end
        else
          s_next.shf = {s_reg.shf[FRAME_BITS-2:0], 1'b0};
        s_next.sdo = (s_reg.cnt == 8'hff) ? I_TAG[TAG_BITS-1] : s_reg.shf[FRAME_BITS-2];
        s_next.cnt = s_reg.cnt + 8'h01;
        s_next.sync = (s_reg.cnt >= 8'hfe) || (s_reg.cnt < 8'h0e);
      end
    end
  end
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      s_reg <= '0;
      s_reg.cnt <= 8'hf0;
    end
    else
      s_reg <= s_next;
  end
  assign link.bit_clk = s_reg.bclk;
  assign link.sync = s_reg.sync;
  assign link.sdata_out = s_reg.sdo;
  assign O_FRAME_START = s_reg.start;
endmodule : aclink_ctl_end
`default_nettype wire

// ===== aclink_sva.sv
`timescale 1ns/10ps
`default_nettype none
module aclink_sva (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic bit_clk,
  input wire logic sync,
  input wire logic sdata_out
);
  logic [12:0] cnt_reg;
  logic prev_reg;
  logic seen_reg;
  // cycles since sync last rose; the first frame after reset has no start to measure from
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cnt_reg <= 13'h0;
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= sync;
      cnt_reg <= (sync && !prev_reg) ? 13'h1 : cnt_reg + 13'h1;
      seen_reg <= seen_reg | (sync && !prev_reg);
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_sync_width: assert property ($fell(sync) |-> cnt_reg == 13'h100)
    else $error("sync high time wrong");
  a_frame_len: assert property ($rose(sync) && seen_reg |-> cnt_reg == 13'h1000)
    else $error("frame length wrong");
  a_sync_edge: assert property ($changed(sync) |-> $rose(bit_clk))
    else $error("sync moved off rising bit clock");
  a_data_edge: assert property ($changed(sdata_out) |-> $rose(bit_clk))
    else $error("data moved off rising bit clock");
  a_clk_high: assert property ($rose(bit_clk) |-> bit_clk[*8] ##1 !bit_clk)
    else $error("bit clock high phase wrong");
  a_clk_low: assert property ($fell(bit_clk) |-> !bit_clk[*8] ##1 bit_clk)
    else $error("bit clock low phase wrong");
  a_sync_rise: assert property ($rose(sync) |-> sync[*8])
    else $error("sync pulse too short");
  a_sync_low: assert property ($fell(sync) |-> !sync[*8])
    else $error("sync back too early");
endmodule : aclink_sva
`default_nettype wire

// ===== tb_ac_link_output_frame_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_ac_link_output_frame_decoder;
  import aclink_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] tag = 16'h0;
  logic [239:0] slots = 240'h0;
  logic [1:0] cid = 2'h0;
  logic [1:0] smap = 2'h0;
  logic gsrc = 1'b0;
  logic rdy = 1'b1;
  logic alt = 1'b0;
  logic smp, dfs;
  int smp_n;
  logic [4:0] gdir = 5'h00;
  logic [4:0] gstat = 5'h00;
  logic wr, rd, cfs;
  logic [6:0] idx;
  logic [15:0] wval;
  logic [19:0] lft, rgt;
  logic [4:0] gout;
  int bad_count = 0;
  int cmp_count = 0;
  int wr_n, rd_n;
  aclink_if link();
  aclink_ctl_end i_aclink_ctl_end (.I_CLK(clk), .I_RST(rst), .link(link), .I_TAG(tag),
    .I_SLOTS(slots), .O_FRAME_START(cfs));
  aclink_dev_end i_aclink_dev_end (.I_CLK(clk), .I_RST(rst), .link(link),
    .I_CODEC_IDENTITY_SETTING(cid), .I_SLOT_MAP_SELECT(smap), .I_ALTERNATE_SLOT_MAP(alt),
    .I_GPIO_OUTPUT_SOURCE_SELECT(gsrc), .I_GPIO_DIR_OUT(gdir), .I_GPIO_STATUS_VALUE(gstat),
    .I_LINK_READY(rdy), .O_REG_WRITE(wr), .O_REG_READ(rd), .O_REGISTER_INDEX(idx),
    .O_WRITE_VALUE(wval), .O_LEFT_SAMPLE(lft), .O_RIGHT_SAMPLE(rgt), .O_SAMPLE_STROBE(smp),
    .O_GPIO_OUT(gout), .O_FRAME_START(dfs));
  aclink_sva i_aclink_sva (.I_CLK(clk), .I_RST(rst), .bit_clk(link.bit_clk),
    .sync(link.sync), .sdata_out(link.sdata_out));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (wr === 1'b1) wr_n++;
    if (rd === 1'b1) rd_n++;
    if (smp === 1'b1) smp_n++;
  end
  // slot k carries base+k so a wrong slot choice shows in the sample value
  task automatic xfer(input logic [15:0] t, input logic [19:0] s1, s2, s12, base);
    logic [239:0] v;
    v = {s1, s2, 180'h0, s12};
    for (int k = 3; k <= 11; k++)
      v[239 - 20 * (k - 1) -: 20] = base + 20'(k);
    wr_n = 0;
    rd_n = 0;
    smp_n = 0;
    tag <= t;
    slots <= v;
    // the start loads the frame; an idle tag follows so nothing is sent twice
    @(posedge clk iff cfs);
    tag <= 16'h0;
    @(posedge clk iff dfs);
    // return early enough that the next tag meets the following load
    repeat (2) @(posedge clk);
  endtask : xfer
  task automatic t_write;
    xfer(16'he000, {1'b0, 7'h12, 12'h0}, 20'hbeef0, 20'h0, 20'h0);
    `CHK("write", 1, wr_n)
    `CHK("strobe", 1, smp_n)
    `CHK("index", 7'h12, idx)
    `CHK("wvalue", 16'hbeef, wval)
  endtask : t_write
  task automatic t_read;
    xfer(16'hc000, {1'b1, 7'h24, 12'h0}, 20'h12340, 20'h0, 20'h0);
    `CHK("read", 1, rd_n)
    `CHK("nowrite", 0, wr_n)
    `CHK("rindex", 7'h24, idx)
    `CHK("wkept", 16'hbeef, wval)
  endtask : t_read
  task automatic t_refuse;
    logic [15:0] tt [5] = '{16'h6000, 16'he001, 16'he000, 16'hc000, 16'he000};
    for (int c = 0; c < 5; c++)
    begin
      rdy <= (c != 4);
      xfer(tt[c], {1'b0, (c == 2) ? 7'h13 : 7'h12, 12'h0}, 20'h11110, 20'h0, 20'h0);
      `CHK("refused", 0, wr_n + rd_n)
      `CHK("vstrobe", c != 0, smp_n)
    end
    rdy <= 1'b1;
  endtask : t_refuse
  task automatic t_second;
    cid <= 2'h1;
    xfer(16'h8001, {1'b0, 7'h30, 12'h0}, 20'h5a5a0, 20'h0, 20'h0);
    `CHK("secwrite", 1, wr_n)
    `CHK("secvalue", 16'h5a5a, wval)
    cid <= 2'h0;
  endtask : t_second
  task automatic t_gpio;
    gdir <= 5'h05;
    xfer(16'h8008, 20'h0, 20'h0, 20'h001f0, 20'h0);
    `CHK("gpionow", 5'h00, gout)
    @(posedge clk iff dfs);
    repeat (2) @(posedge clk);
    `CHK("gpio", 5'h05, gout)
    gstat <= 5'h0e;
    gsrc <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("gpiosrc", 5'h04, gout)
    gsrc <= 1'b0;
  endtask : t_gpio
  task automatic t_samples;
    smap <= 2'h1;
    xfer(16'h8180, 20'h0, 20'h0, 20'h0, 20'h12340);
    `CHK("left", 20'h12347, lft)
    `CHK("right", 20'h12348, rgt)
    smap <= 2'h0;
    xfer(16'h8800, 20'h0, 20'h0, 20'h0, 20'h55500);
    `CHK("lkept", 20'h12347, lft)
    `CHK("right2", 20'h55504, rgt)
    alt <= 1'b1;
    xfer(16'h8180, 20'h0, 20'h0, 20'h0, 20'h66600);
    `CHK("altleft", 20'h66607, lft)
    `CHK("altright", 20'h66608, rgt)
    alt <= 1'b0;
  endtask : t_samples
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #(5 * 80000);
    bad_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk iff cfs);
    t_write;
    t_read;
    t_refuse;
    t_second;
    t_gpio;
    t_samples;
    report_and_stop;
  end
endmodule : tb_ac_link_output_frame_decoder
`default_nettype wire
